// ### design/smc_servo_mode.sv
`timescale 1ns/1ps
`include "smc_consts.svh"

// Contract
// [R1] Mode-select object is written; active mode is shown by a separate read-only object.
// [R2] Codes 1, 3 and 4 select profile position, velocity and torque.
// [R3] Code 6 selects homing; sync cycle must not be shorter than 1 ms.
// [R4] Code 10 selects cyclic torque; sync cycle at least 125 us.
// [R5] Code 9 selects cyclic velocity; sync cycle at least 500 us.
// [R6] Master keeps cycles above 1 ms a multiple of 250 us.
// [R7] Code 8 selects cyclic position; one command per master cycle is followed.
// [R8] Master keeps the cyclic position cycle at 1 ms or longer.
// [R9] Cyclic position commands are timed only by distributed-clock sync events.
// [R10] Leaving cyclic position mode drops every unexecuted position command.
// [R11] Master waits 1 ms after entering cyclic mode before commanding.
// [R12] Cyclic position targets are absolute positions only.
// [R13] System counts as started only when control word bits 0..3 are all one.
// [R14] Bits 0, 1, 3 request ready, main power and operation, active high.
// [R15] Bit 2 low requests quick stop; high runs normally.
// [R16] Pause bit set halts using the pause option; clear has no effect.
// [R17] Target reached only when error stays in window for window time.
// [R18] Alarm when target to actual difference exceeds following error limit.
// [R19] Unsupported mode code keeps the previous active mode and display.
module smc_servo_mode #(
    parameter int CYCLES_PER_MS = `SMC_TIME_MS_NS / `SMC_CLK_PERIOD_NS,
    parameter int MIN_CYC_1MS   = `SMC_CYC_1MS_US * 1000 / `SMC_CLK_PERIOD_NS,
    parameter int MIN_CYC_500US = `SMC_CYC_500_US * 1000 / `SMC_CLK_PERIOD_NS,
    parameter int MIN_CYC_125US = `SMC_CYC_125_US * 1000 / `SMC_CLK_PERIOD_NS
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    // Object access port
    input  wire logic        objWrite,
    input  wire logic        objRead,
    input  wire logic [15:0] objIndex,
    input  wire logic [7:0]  objSub,
    input  wire logic [31:0] objWdata,
    output logic      [31:0] objRdata,
    output logic             objAck,
    output logic             objErr,
    // Distributed-clock sync
    input  wire logic        dcSync,
    input  wire logic        dcLocked,
    // Position command stream to the loop
    output logic             cmdValid,
    input  wire logic        cmdReady,
    output logic      [31:0] cmdPos,
    // Feedback
    input  wire logic [31:0] actualPos,
    // Drive status
    output logic      [7:0]  modeDisplay,
    output logic             sysStarted,
    output logic             servoReady,
    output logic             mainPowerOn,
    output logic             servoRun,
    output logic             quickStop,
    output logic             pauseReq,
    output logic      [15:0] pauseOption,
    output logic             targetReached,
    output logic             followAlarm,
    output logic             cycleFault,
    output logic             cmdOverrun
);

    smc_pkg::smc_state_t st;
    smc_pkg::smc_state_t next_st;

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic modeSupported(input logic [7:0] m);
        case (m)
            `SMC_MODE_PP, `SMC_MODE_PV, `SMC_MODE_PT, `SMC_MODE_HOME,
            `SMC_MODE_CYC_POS, `SMC_MODE_CSV, `SMC_MODE_CST: modeSupported = 1'b1;
            default: modeSupported = 1'b0;
        endcase
    endfunction

    function automatic logic [23:0] minCycles(input logic [7:0] m);
        case (m)
            `SMC_MODE_PP, `SMC_MODE_HOME, `SMC_MODE_CYC_POS: minCycles = 24'(MIN_CYC_1MS);
            `SMC_MODE_PV, `SMC_MODE_CSV:                    minCycles = 24'(MIN_CYC_500US);
            `SMC_MODE_PT, `SMC_MODE_CST:                    minCycles = 24'(MIN_CYC_125US);
            default:                                        minCycles = 24'h000000;
        endcase
    endfunction

    // Returns {hit, slot} for the gain/filter sub-objects
    function automatic logic [3:0] gainSlot(input logic [15:0] idx, input logic [7:0] sub);
        gainSlot = 4'h0;
        if (idx == `SMC_IDX_GAIN_A) begin
            case (sub)
                8'h01:   gainSlot = 4'h8;
                8'h02:   gainSlot = 4'h9;
                8'h03:   gainSlot = 4'ha;
                8'h09:   gainSlot = 4'hb;
                8'h0a:   gainSlot = 4'hc;
                default: gainSlot = 4'h0;
            endcase
        end else if (idx == `SMC_IDX_GAIN_B) begin
            case (sub)
                8'h03:   gainSlot = 4'hd;
                8'h07:   gainSlot = 4'he;
                8'h08:   gainSlot = 4'hf;
                default: gainSlot = 4'h0;
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // Combinational terms
    // ------------------------------------------------------------
    logic        inCycPos;
    logic        leavingCycPos;
    logic        fifoFull;
    logic        fifoEmpty;
    logic        doPush;
    logic        doPop;
    logic        msTick;
    logic [32:0] posDiff;
    logic [32:0] absErr;
    logic        inWindow;
    logic [3:0]  gs;
    logic        wrSub0;

    assign inCycPos  = (st.activeMode == `SMC_MODE_CYC_POS);
    assign fifoFull  = (st.fifoCnt == 2'd2);
    assign fifoEmpty = (st.fifoCnt == 2'd0);
    assign gs        = gainSlot(objIndex, objSub);
    assign wrSub0    = objWrite && (objSub == 8'h00);
    // Mode switch takes effect on the accepted write only
    assign leavingCycPos = inCycPos && wrSub0 && (objIndex == `SMC_IDX_MODE_SEL)
                           && modeSupported(objWdata[7:0]) && (objWdata[7:0] != `SMC_MODE_CYC_POS);
    // Commands move only on a sync event while locked; a full buffer holds them pending
    assign doPush    = inCycPos && dcLocked && dcSync && st.pending && !fifoFull && !leavingCycPos; // R9
    assign doPop     = cmdValid && cmdReady;
    assign msTick    = (st.msPre == 24'(CYCLES_PER_MS - 1));
    assign posDiff   = {st.target[31], st.target} - {actualPos[31], actualPos};
    assign absErr    = posDiff[32] ? (33'h0 - posDiff) : posDiff;
    assign inWindow  = (absErr <= {1'b0, st.winSize});

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_st     = st;
        next_st.ack = 1'b0;
        next_st.err = 1'b0;

        // Object writes
        if (objWrite) begin
            next_st.ack = 1'b1;
            if (gs[3]) begin
                next_st.gains[gs[2:0]] = objWdata[15:0];
            end else if (objSub != 8'h00) begin
                next_st.err = 1'b1;
            end else begin
                case (objIndex)
                    `SMC_IDX_CTRL_WORD:  next_st.ctrlWord = objWdata[15:0];
                    `SMC_IDX_MODE_SEL: begin
                        next_st.modeSelect = objWdata[7:0]; // R1
                        if (modeSupported(objWdata[7:0])) begin
                            next_st.activeMode = objWdata[7:0]; // R2
                        end else begin
                            next_st.err = 1'b1; // R19
                        end
                    end
                    `SMC_IDX_PAUSE_OPT:  next_st.pauseOpt    = objWdata[15:0];
                    `SMC_IDX_FOLLOW_LIM: next_st.followLimit = objWdata;
                    `SMC_IDX_WIN_SIZE:   next_st.winSize     = objWdata;
                    `SMC_IDX_WIN_TIME:   next_st.winTime     = objWdata[15:0];
                    `SMC_IDX_TORQ_CEIL:  next_st.torqueCeil  = objWdata[15:0];
                    `SMC_IDX_TARGET: begin
                        next_st.target = objWdata;
                        if (inCycPos) begin
                            next_st.pending = 1'b1; // R7
                        end
                    end
                    `SMC_IDX_POS_ADD:    next_st.posAdd  = objWdata;
                    `SMC_IDX_VEL_ADD:    next_st.velAdd  = objWdata;
                    `SMC_IDX_TORQ_ADD:   next_st.torqAdd = objWdata;
                    default:             next_st.err     = 1'b1; // read-only or unmapped
                endcase
            end
        end else if (objRead) begin
            next_st.ack   = 1'b1;
            next_st.rdata = 32'h00000000;
            if (gs[3]) begin
                next_st.rdata = {16'h0000, st.gains[gs[2:0]]};
            end else if (objSub != 8'h00) begin
                next_st.err = 1'b1;
            end else begin
                case (objIndex)
                    `SMC_IDX_CTRL_WORD:  next_st.rdata = {16'h0000, st.ctrlWord};
                    `SMC_IDX_MODE_SEL:   next_st.rdata = {24'h000000, st.modeSelect};
                    `SMC_IDX_MODE_DISP:  next_st.rdata = {24'h000000, st.activeMode}; // R1
                    `SMC_IDX_PAUSE_OPT:  next_st.rdata = {16'h0000, st.pauseOpt};
                    `SMC_IDX_FOLLOW_LIM: next_st.rdata = st.followLimit;
                    `SMC_IDX_WIN_SIZE:   next_st.rdata = st.winSize;
                    `SMC_IDX_WIN_TIME:   next_st.rdata = {16'h0000, st.winTime};
                    `SMC_IDX_TORQ_CEIL:  next_st.rdata = {16'h0000, st.torqueCeil};
                    `SMC_IDX_TARGET:     next_st.rdata = st.target;
                    `SMC_IDX_POS_ADD:    next_st.rdata = st.posAdd;
                    `SMC_IDX_VEL_ADD:    next_st.rdata = st.velAdd;
                    `SMC_IDX_TORQ_ADD:   next_st.rdata = st.torqAdd;
                    default:             next_st.err   = 1'b1;
                endcase
            end
        end

        // Two-entry command buffer; absolute target plus position addend
        if (doPush) begin
            next_st.fifoData[st.wrPtr] = st.target + st.posAdd; // R12
            next_st.wrPtr   = ~st.wrPtr;
            // A target written on the push edge must stay pending, not be lost
            next_st.pending = wrSub0 && (objIndex == `SMC_IDX_TARGET);
        end
        if (doPop) begin
            next_st.rdPtr = ~st.rdPtr;
        end
        next_st.fifoCnt = st.fifoCnt + {1'b0, doPush} - {1'b0, doPop};
        if (leavingCycPos) begin
            next_st.fifoCnt = 2'd0; // R10
            next_st.wrPtr   = 1'b0;
            next_st.rdPtr   = 1'b0;
            next_st.pending = 1'b0;
        end

        // Sync period check against the mode's shortest cycle
        if (dcSync) begin
            next_st.periodCnt = 24'h000001;
            next_st.seenSync  = 1'b1;
        end else if (st.periodCnt != 24'hffffff) begin
            next_st.periodCnt = st.periodCnt + 24'h000001;
        end
        if (wrSub0 && objIndex == `SMC_IDX_CTRL_WORD && objWdata[`SMC_CW_FAULT_CLR]) begin
            next_st.cycleFault = 1'b0;
        end
        // Set wins over the clear
        if (dcSync && st.seenSync && st.periodCnt < minCycles(st.activeMode)) begin
            next_st.cycleFault = 1'b1; // R3 R4 R5
        end

        // Arrival window timing in milliseconds
        next_st.msPre = msTick ? 24'h000000 : st.msPre + 24'h000001;
        if (!inWindow) begin
            next_st.winMs = 16'h0000;
        end else if (msTick && st.winMs != 16'hffff) begin
            next_st.winMs = st.winMs + 16'h0001;
        end
        next_st.targetReached = inWindow && (st.winMs >= st.winTime); // R17
        next_st.followAlarm   = (absErr > {1'b0, st.followLimit}); // R18
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st          <= '0;
            st.ctrlWord <= `SMC_CW_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign objRdata      = st.rdata;
    assign objAck        = st.ack;
    assign objErr        = st.err;
    assign cmdValid      = !fifoEmpty;
    assign cmdPos        = st.fifoData[st.rdPtr];
    assign modeDisplay   = st.activeMode;
    assign sysStarted    = (st.ctrlWord[3:0] == 4'hf); // R13
    assign servoReady    = st.ctrlWord[`SMC_CW_READY]; // R14
    assign mainPowerOn   = st.ctrlWord[`SMC_CW_MAIN_ON]; // R14
    assign servoRun      = st.ctrlWord[`SMC_CW_RUN]; // R14
    assign quickStop     = !st.ctrlWord[`SMC_CW_QSTOP_N]; // R15
    assign pauseReq      = st.ctrlWord[`SMC_CW_PAUSE]; // R16
    assign pauseOption   = st.pauseOpt; // R16
    assign targetReached = st.targetReached;
    assign followAlarm   = st.followAlarm;
    assign cycleFault    = st.cycleFault;
    // Flags a sync event that finds a command still pending and the buffer full
    assign cmdOverrun    = st.pending && inCycPos && dcSync && fifoFull;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_mode_display;
        @(posedge clk_sys) disable iff (sys_rst)
        (wrSub0 && objIndex == `SMC_IDX_MODE_SEL && modeSupported(objWdata[7:0]))
            |=> (modeDisplay == $past(objWdata[7:0]));
    endproperty
    a_mode_display: assert property (p_mode_display) else $error("mode display not updated"); // R1

    property p_bad_mode;
        @(posedge clk_sys) disable iff (sys_rst)
        (objWrite && objIndex == `SMC_IDX_MODE_SEL && !modeSupported(objWdata[7:0]))
            |=> ($stable(modeDisplay) && objErr);
    endproperty
    a_bad_mode: assert property (p_bad_mode) else $error("unsupported mode changed display"); // R19

    property p_flush;
        @(posedge clk_sys) disable iff (sys_rst)
        leavingCycPos |=> (!cmdValid && !st.pending);
    endproperty
    a_flush: assert property (p_flush) else $error("commands kept after leaving cyclic position"); // R10

    property p_push_sync;
        @(posedge clk_sys) disable iff (sys_rst)
        (st.fifoCnt > $past(st.fifoCnt)) |-> $past(dcSync && dcLocked && inCycPos);
    endproperty
    a_push_sync: assert property (p_push_sync) else $error("command queued without sync"); // R9

    property p_started;
        @(posedge clk_sys) disable iff (sys_rst)
        sysStarted == (servoReady && mainPowerOn && !quickStop && servoRun);
    endproperty
    a_started: assert property (p_started) else $error("started flag mismatch"); // R13

    property p_qstop;
        @(posedge clk_sys) disable iff (sys_rst)
        (wrSub0 && objIndex == `SMC_IDX_CTRL_WORD) |=> (quickStop == !$past(objWdata[2]));
    endproperty
    a_qstop: assert property (p_qstop) else $error("quick stop polarity wrong"); // R15

    property p_pause;
        @(posedge clk_sys) disable iff (sys_rst)
        (wrSub0 && objIndex == `SMC_IDX_CTRL_WORD) |=> (pauseReq == $past(objWdata[8]));
    endproperty
    a_pause: assert property (p_pause) else $error("pause bit not followed"); // R16

    property p_reached;
        @(posedge clk_sys) disable iff (sys_rst)
        targetReached |-> ($past(inWindow) && $past(st.winMs) >= $past(st.winTime));
    endproperty
    a_reached: assert property (p_reached) else $error("target reached too early"); // R17

    property p_follow;
        @(posedge clk_sys) disable iff (sys_rst)
        ($past(absErr) > {1'b0, $past(st.followLimit)}) |-> followAlarm;
    endproperty
    a_follow: assert property (p_follow) else $error("following alarm missed"); // R18

    property p_cycle;
        @(posedge clk_sys) disable iff (sys_rst)
        (dcSync && st.seenSync && (inCycPos || st.activeMode == `SMC_MODE_HOME)
            && st.periodCnt < 24'(MIN_CYC_1MS)) |=> cycleFault;
    endproperty
    a_cycle: assert property (p_cycle) else $error("short cycle not flagged"); // R3

    property p_abs;
        @(posedge clk_sys) disable iff (sys_rst)
        doPush |=> (st.fifoData[$past(st.wrPtr)] == $past(st.target) + $past(st.posAdd));
    endproperty
    a_abs: assert property (p_abs) else $error("queued position not absolute"); // R12

endmodule

// ### shared/smc_consts.svh
`ifndef SMC_CONSTS_SVH
`define SMC_CONSTS_SVH

// Object indexes
`define SMC_IDX_GAIN_A      16'h2006
`define SMC_IDX_GAIN_B      16'h2007
`define SMC_IDX_CTRL_WORD   16'h6040
`define SMC_IDX_MODE_SEL    16'h6060
`define SMC_IDX_MODE_DISP   16'h6061
`define SMC_IDX_PAUSE_OPT   16'h605d
`define SMC_IDX_FOLLOW_LIM  16'h6065
`define SMC_IDX_WIN_SIZE    16'h6067
`define SMC_IDX_WIN_TIME    16'h6068
`define SMC_IDX_TORQ_CEIL   16'h6072
`define SMC_IDX_TARGET      16'h607a
`define SMC_IDX_POS_ADD     16'h60b0
`define SMC_IDX_VEL_ADD     16'h60b1
`define SMC_IDX_TORQ_ADD    16'h60b2

// Mode codes
`define SMC_MODE_NONE       8'h00
`define SMC_MODE_PP         8'h01
`define SMC_MODE_PV         8'h03
`define SMC_MODE_PT         8'h04
`define SMC_MODE_HOME       8'h06
`define SMC_MODE_CYC_POS    8'h08
`define SMC_MODE_CSV        8'h09
`define SMC_MODE_CST        8'h0a

// Control word bit positions
`define SMC_CW_READY        0
`define SMC_CW_MAIN_ON      1
`define SMC_CW_QSTOP_N      2
`define SMC_CW_RUN          3
`define SMC_CW_FAULT_CLR    7
`define SMC_CW_PAUSE        8
`define SMC_CW_RESET        16'h0000

// Timing
`define SMC_CLK_PERIOD_NS   4
`define SMC_TIME_MS_NS      1000000
`define SMC_CYC_1MS_US      1000
`define SMC_CYC_500_US      500
`define SMC_CYC_125_US      125

`endif

// ### shared/smc_pkg.sv
package smc_pkg;

    typedef logic [1:0][31:0] smc_fifo_mem_t;

    typedef struct packed {
        logic [15:0]      ctrlWord;
        logic [7:0]       modeSelect;
        logic [7:0]       activeMode;
        logic [15:0]      pauseOpt;
        logic [31:0]      followLimit;
        logic [31:0]      winSize;
        logic [15:0]      winTime;
        logic [15:0]      torqueCeil;
        logic [31:0]      target;
        logic [31:0]      posAdd;
        logic [31:0]      velAdd;
        logic [31:0]      torqAdd;
        logic [7:0][15:0] gains;
        logic             pending;
        smc_fifo_mem_t    fifoData;
        logic [1:0]       fifoCnt;
        logic             wrPtr;
        logic             rdPtr;
        logic [23:0]      periodCnt;
        logic             seenSync;
        logic             cycleFault;
        logic [23:0]      msPre;
        logic [15:0]      winMs;
        logic             targetReached;
        logic             followAlarm;
        logic [31:0]      rdata;
        logic             ack;
        logic             err;
    } smc_state_t;

endpackage

// ### tb/smc_sync_master.sv
`timescale 1ns/1ps
module smc_sync_master (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    // Bench control
    input  wire logic        syncEn,
    input  wire logic        lockEn,
    input  wire logic [15:0] period,
    // Sync toward the drive
    output logic             dcSync,
    output logic             dcLocked
);
    logic [15:0] count;

    // ----
    // Distributed-clock sync source of the master
    // ----
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            count <= 16'h0000;
            dcSync <= 1'b0;
            dcLocked <= 1'b0;
        end else begin
            dcLocked <= lockEn;
            dcSync <= 1'b0;
            count <= count + 16'h0001;
            if (!syncEn) begin
                count <= 16'h0000;
            end else if (count >= period - 16'h0001) begin
                count <= 16'h0000;
                dcSync <= 1'b1;
            end
        end
    end
endmodule

// ### tb/test_servo_mode_select_csp_command.sv
`timescale 1ns/1ps
module test_servo_mode_select_csp_command;
    localparam int MS = 40;
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    logic        objWrite = 1'b0;
    logic        objRead = 1'b0;
    logic [15:0] objIndex = 16'h0000;
    logic [7:0]  objSub = 8'h00;
    logic [31:0] objWdata = 32'h0;
    logic        cmdReady = 1'b0;
    logic [31:0] actualPos = 32'h0;
    logic        syncEn = 1'b0;
    logic        lockEn = 1'b0;
    logic [15:0] period = 16'h0028;
    logic [31:0] objRdata, cmdPos;
    logic [15:0] pauseOption;
    logic [7:0]  modeDisplay;
    logic        objAck, objErr, dcSync, dcLocked, cmdValid, sysStarted, servoReady, mainPowerOn;
    logic        servoRun, quickStop, pauseReq, targetReached, followAlarm, cycleFault, cmdOverrun;
    int          num_errors = 0;
    int          check_count = 0;
    int          overrunSeen = 0;
    int          i;
    logic [31:0] codes [7] = '{32'h1, 32'h3, 32'h4, 32'h6, 32'h8, 32'h9, 32'ha};
    logic [31:0] cw [4] = '{32'h000f, 32'h000b, 32'h0107, 32'h0008};
    logic [31:0] cwExp [4] = '{32'h1d, 32'h0f, 32'h2c, 32'h03};
    logic [31:0] fm [5] = '{32'h8, 32'h9, 32'h6, 32'ha, 32'h3};
    logic [15:0] fp [5] = '{16'h0014, 16'h0014, 16'h0014, 16'h0005, 16'h0005};
    logic [31:0] ff [5] = '{32'h1, 32'h0, 32'h1, 32'h0, 32'h1};

    always #2 clk_sys = ~clk_sys;
    // Comb pulse, so it is caught on every edge
    always @(posedge clk_sys) if (cmdOverrun === 1'b1) overrunSeen++;

    smc_servo_mode #(.CYCLES_PER_MS(MS), .MIN_CYC_1MS(40), .MIN_CYC_500US(20), .MIN_CYC_125US(5)) uut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .objWrite(objWrite), .objRead(objRead),
        .objIndex(objIndex), .objSub(objSub), .objWdata(objWdata), .objRdata(objRdata),
        .objAck(objAck), .objErr(objErr), .dcSync(dcSync), .dcLocked(dcLocked),
        .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdPos(cmdPos), .actualPos(actualPos),
        .modeDisplay(modeDisplay), .sysStarted(sysStarted), .servoReady(servoReady),
        .mainPowerOn(mainPowerOn), .servoRun(servoRun), .quickStop(quickStop), .pauseReq(pauseReq),
        .pauseOption(pauseOption), .targetReached(targetReached), .followAlarm(followAlarm),
        .cycleFault(cycleFault), .cmdOverrun(cmdOverrun));

    smc_sync_master syncModel (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .syncEn(syncEn), .lockEn(lockEn),
        .period(period), .dcSync(dcSync), .dcLocked(dcLocked));

    // ----
    // Checking and object access
    // ----
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic acc(input logic w, input logic [15:0] idx, input logic [7:0] sub,
                       input logic [31:0] d, input logic err);
        @(posedge clk_sys);
        objWrite <= w;
        objRead <= !w;
        objIndex <= idx;
        objSub <= sub;
        objWdata <= d;
        @(posedge clk_sys);
        objWrite <= 1'b0;
        objRead <= 1'b0;
        #1;
        check("objAck", objAck, 32'h1);
        check("objErr", objErr, {31'h0, err});
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d, input logic err);
        acc(1'b1, idx, sub, d, err);
    endtask

    task automatic rd(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] exp);
        acc(1'b0, idx, sub, 32'h0, 1'b0);
        check("objRdata", objRdata, exp);
    endtask

    task automatic wait_sync(input int n);
        int k;
        repeat (n) begin
            k = 0;
            do begin
                @(posedge clk_sys);
                k++;
            end while (dcSync !== 1'b1 && k < 200);
            if (k >= 200) begin
                $display("[ERR] dcSync expected pulse seen none");
                num_errors++;
                finish_test();
            end
        end
        #1;
    endtask

    // ----
    // Test sequence
    // ----
    initial begin
        repeat (20) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        #1;
        check("modeDisplay", modeDisplay, 32'h0);
        check("quickStop", quickStop, 32'h1);
        check("sysStarted", sysStarted, 32'h0);
        check("cmdValid", cmdValid, 32'h0);
        rd(16'h6040, 8'h00, 32'h0);
        $display("test reset done");
        foreach (codes[n]) begin
            wr(16'h6060, 8'h00, codes[n], 1'b0);
            rd(16'h6061, 8'h00, codes[n]);
            check("modeDisplay", modeDisplay, codes[n]);
        end
        wr(16'h6060, 8'h00, 32'h5, 1'b1);
        rd(16'h6061, 8'h00, 32'ha);
        wr(16'h6061, 8'h00, 32'h1, 1'b1);
        wr(16'h1234, 8'h00, 32'h1, 1'b1);
        wr(16'h2006, 8'h04, 32'h1, 1'b1);
        wr(16'h2006, 8'h03, 32'h55aa, 1'b0);
        rd(16'h2006, 8'h03, 32'h55aa);
        $display("test modes done");
        foreach (cw[n]) begin
            wr(16'h6040, 8'h00, cw[n], 1'b0);
            check("ctrl", {26'h0, pauseReq, sysStarted, servoReady, mainPowerOn, quickStop, servoRun}, cwExp[n]);
        end
        wr(16'h605d, 8'h00, 32'h3, 1'b0);
        check("pauseOption", pauseOption, 32'h3);
        $display("test control done");
        @(posedge clk_sys);
        syncEn <= 1'b1;
        lockEn <= 1'b1;
        wr(16'h6060, 8'h00, 32'h8, 1'b0);
        repeat (MS) @(posedge clk_sys);
        wr(16'h60b0, 8'h00, 32'h64, 1'b0);
        wr(16'h607a, 8'h00, 32'h3e8, 1'b0);
        wait_sync(2);
        check("cmdValid", cmdValid, 32'h1);
        check("cmdPos", cmdPos, 32'h44c);
        wr(16'h607a, 8'h00, 32'h7d0, 1'b0);
        wait_sync(2);
        wr(16'h607a, 8'h00, 32'hbb8, 1'b0);
        wait_sync(2);
        check("overrun", {31'h0, overrunSeen != 0}, 32'h1);
        check("cmdPos", cmdPos, 32'h44c);
        @(posedge clk_sys);
        cmdReady <= 1'b1;
        @(posedge clk_sys);
        cmdReady <= 1'b0;
        #1;
        check("cmdPos", cmdPos, 32'h834);
        wr(16'h6060, 8'h00, 32'h1, 1'b0);
        @(posedge clk_sys);
        #1;
        check("cmdValid", cmdValid, 32'h0);
        wr(16'h6060, 8'h00, 32'h8, 1'b0);
        @(posedge clk_sys);
        lockEn <= 1'b0;
        repeat (MS) @(posedge clk_sys);
        wr(16'h607a, 8'h00, 32'h1000, 1'b0);
        wait_sync(2);
        check("cmdValid", cmdValid, 32'h0);
        @(posedge clk_sys);
        lockEn <= 1'b1;
        wait_sync(2);
        check("cmdPos", cmdPos, 32'h1064);
        @(posedge clk_sys);
        cmdReady <= 1'b1;
        @(posedge clk_sys);
        cmdReady <= 1'b0;
        #1;
        check("cmdValid", cmdValid, 32'h0);
        $display("test stream done");
        for (int n = 0; n < 5; n++) begin
            wr(16'h6060, 8'h00, fm[n], 1'b0);
            @(posedge clk_sys);
            period <= fp[n];
            wait_sync(2);
            wr(16'h6040, 8'h00, 32'h80, 1'b0);
            wait_sync(2);
            check("cycleFault", cycleFault, ff[n]);
        end
        $display("test cycle done");
        wr(16'h6060, 8'h00, 32'h1, 1'b0);
        wr(16'h6065, 8'h00, 32'h10, 1'b0);
        wr(16'h6067, 8'h00, 32'h8, 1'b0);
        wr(16'h6068, 8'h00, 32'h2, 1'b0);
        wr(16'h607a, 8'h00, 32'h200, 1'b0);
        repeat (2) @(posedge clk_sys);
        #1;
        check("followAlarm", followAlarm, 32'h1);
        @(posedge clk_sys);
        actualPos <= 32'h1f0;
        repeat (3) @(posedge clk_sys);
        #1;
        check("followAlarm", followAlarm, 32'h0);
        check("targetReached", targetReached, 32'h0);
        @(posedge clk_sys);
        actualPos <= 32'h1f8;
        i = 0;
        while (targetReached !== 1'b1 && i < 3 * MS + 10) begin
            @(posedge clk_sys);
            i++;
        end
        check("reachDelay", {31'h0, i >= MS && i < 3 * MS + 10}, 32'h1);
        @(posedge clk_sys);
        actualPos <= 32'h1f7;
        repeat (3) @(posedge clk_sys);
        #1;
        check("targetReached", targetReached, 32'h0);
        $display("test status done");
        finish_test();
    end
endmodule
